// file: fbo_host.sv
/*
 * Host controller for an asynchronous parallel flash bus: read and command write cycles,
 * deep power-down and wake-up pacing, byte or word width.
 * Assumes fbo_pkg and fbo_sync are compiled first; the flash data and busy pins are
 * joined to a wire by the surroundings, the busy pin pulled up.
 */
// What this block does
// - Reset/power-down is held high during every read cycle.
// - User writes the read-mode command before reading.
// - Data lines driven by host only while output enable is high.
// - Reset/power-down low enters power-down; held low at least 100 ns.
// - Wait wake-to-read before reads and wake-to-write before command writes.
// - System reset drives reset/power-down low.
// - User supplies the right address for erase, program and lock commands.
`timescale 1ns/1ps
`default_nettype none
module fbo_host #(
	parameter int ADDR_W = 21,
	parameter int DATA_W = 16
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic [DATA_W-1:0] req_wdata_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [DATA_W-1:0] rsp_rdata_o,
	input wire logic pwrdown_i,
	input wire logic byte_mode_i,
	output logic busy_o,
	output logic [ADDR_W-1:0] flash_addr_o,
	output logic [DATA_W-1:0] data_lines_o,
	output logic data_lines_oe_o,
	input wire logic [DATA_W-1:0] data_lines_i,
	output logic chip_select_a_n_o,
	output logic chip_select_b_n_o,
	output logic out_en_n_o,
	output logic write_en_n_o,
	output logic reset_powerdown_n_o,
	output logic byte_n_o,
	input wire logic ready_busy_out_i
);

	typedef struct packed {
		fbo_pkg::fbo_state_t st;
		logic [fbo_pkg::CNT_W-1:0] cnt;
		logic [fbo_pkg::CNT_W-1:0] wake;
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic rp_n;
		logic dq_oe;
		logic byte_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
	} fbo_host_state_t;

	localparam fbo_host_state_t Q_RST = '{st: fbo_pkg::ST_PD, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
		byte_n: 1'b1, default: '0};

	fbo_host_state_t q, d;
	logic ready_sync;
	logic rd_ok;
	logic wr_ok;
	logic accept;

	// ****************************************
	// Busy pin input
	// ****************************************
	fbo_sync #(
		.RST_VAL(1'b1)
	) u_busy_sync (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.async_i(ready_busy_out_i),
		.sync_o(ready_sync)
	);

	// Busy pin low while an operation runs; an aborting power-down releases it as soon as it starts.
	assign busy_o = ~ready_sync;

	// ****************************************
	// Request handshake
	// ****************************************
	assign rd_ok = q.wake >= fbo_pkg::WAKE_RD_CNT;
	assign wr_ok = q.wake >= fbo_pkg::WAKE_WR_CNT;
	assign req_ready_o = (q.st == fbo_pkg::ST_IDLE) && !pwrdown_i && (req_write_i ? wr_ok : rd_ok);
	assign accept = req_valid_i && req_ready_o;

	// ****************************************
	// Bus cycle sequencer
	// ****************************************
	always_comb begin
		d = q;
		d.rvalid = 1'b0;
		case (q.st)
			fbo_pkg::ST_PD: begin
				d.rp_n = 1'b0;
				d.cs_n = 1'b1;
				d.oe_n = 1'b1;
				d.we_n = 1'b1;
				d.dq_oe = 1'b0;
				if (q.cnt < fbo_pkg::PD_MIN_CNT - fbo_pkg::CNT_W'(1)) begin
					d.cnt = q.cnt + fbo_pkg::CNT_W'(1);
				end else if (!pwrdown_i) begin
					// Flash comes back in read-array mode; wake timers start here.
					d.rp_n = 1'b1;
					d.wake = '0;
					d.st = fbo_pkg::ST_IDLE;
				end
			end
			fbo_pkg::ST_IDLE: begin
				d.byte_n = ~byte_mode_i;
				if (q.wake != fbo_pkg::WAKE_WR_CNT) begin
					d.wake = q.wake + fbo_pkg::CNT_W'(1);
				end
				if (pwrdown_i) begin
					d.rp_n = 1'b0;
					d.cnt = '0;
					d.st = fbo_pkg::ST_PD;
				end else if (accept) begin
					d.addr = req_addr_i;
					d.cs_n = 1'b0;
					d.cnt = '0;
					if (req_write_i) begin
						d.we_n = 1'b0;
						d.dq = req_wdata_i;
						d.dq_oe = 1'b1;
						d.st = fbo_pkg::ST_WR;
					end else begin
						d.oe_n = 1'b0;
						d.st = fbo_pkg::ST_RD;
					end
				end
			end
			fbo_pkg::ST_RD: begin
				d.cnt = q.cnt + fbo_pkg::CNT_W'(1);
				if (q.cnt == fbo_pkg::RD_CNT - fbo_pkg::CNT_W'(1)) begin
					// Pins are stable after the access time, so a direct sample is safe.
					if (q.byte_n) begin
						d.rdata = data_lines_i;
					end else begin
						d.rdata = {{(DATA_W-fbo_pkg::BYTE_W){1'b0}}, data_lines_i[fbo_pkg::BYTE_W-1:0]};
					end
					d.rvalid = 1'b1;
					d.oe_n = 1'b1;
					d.cs_n = 1'b1;
					d.cnt = '0;
					d.st = fbo_pkg::ST_GAP;
				end
			end
			fbo_pkg::ST_WR: begin
				d.cnt = q.cnt + fbo_pkg::CNT_W'(1);
				if (q.cnt == fbo_pkg::WE_CNT - fbo_pkg::CNT_W'(1)) begin
					// Write strobe rises first so it alone marks the latch point.
					d.we_n = 1'b1;
					d.st = fbo_pkg::ST_WR_REL;
				end
			end
			fbo_pkg::ST_WR_REL: begin
				d.cs_n = 1'b1;
				d.dq_oe = 1'b0;
				d.cnt = '0;
				d.st = fbo_pkg::ST_GAP;
			end
			fbo_pkg::ST_GAP: begin
				d.cnt = q.cnt + fbo_pkg::CNT_W'(1);
				if (q.cnt == fbo_pkg::GAP_CNT - fbo_pkg::CNT_W'(1)) begin
					d.st = fbo_pkg::ST_IDLE;
				end
			end
			default: begin
				d = Q_RST;
			end
		endcase
	end

	// System reset also holds the flash in power-down.
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			q <= Q_RST;
		end else if (clk_en_i) begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rsp_valid_o = q.rvalid && clk_en_i;
	assign rsp_rdata_o = q.rdata;
	assign flash_addr_o = q.addr;
	assign data_lines_o = q.dq;
	assign data_lines_oe_o = q.dq_oe;
	assign chip_select_a_n_o = q.cs_n;
	assign chip_select_b_n_o = q.cs_n;
	assign out_en_n_o = q.oe_n;
	assign write_en_n_o = q.we_n;
	assign reset_powerdown_n_o = q.rp_n;
	assign byte_n_o = q.byte_n;

	// ****************************************
	// Assertions
	// ****************************************
	logic [fbo_pkg::CNT_W-1:0] pd_len_q;

	always_ff @(posedge core_clk_i) begin
		if (reset_i || reset_powerdown_n_o) begin
			pd_len_q <= '0;
		end else if (clk_en_i && pd_len_q != '1) begin
			pd_len_q <= pd_len_q + fbo_pkg::CNT_W'(1);
		end
	end

	AST_NO_OE_WE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!(!out_en_n_o && !write_en_n_o)) else $error("Output and write enable both low.");
	AST_DQ_ONLY_OE_HIGH: assert property (@(posedge core_clk_i) disable iff (reset_i)
		data_lines_oe_o |-> out_en_n_o && !chip_select_a_n_o) else $error("Host drives data while flash may.");
	AST_PD_DESELECT: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!reset_powerdown_n_o |-> chip_select_a_n_o && out_en_n_o && !data_lines_oe_o) else $error("Bus active in power-down.");
	AST_PD_MIN: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$rose(reset_powerdown_n_o) |-> pd_len_q >= fbo_pkg::PD_MIN_CNT) else $error("Power-down pulse too short.");
	AST_WAKE_READ: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$fell(out_en_n_o) |-> q.wake >= fbo_pkg::WAKE_RD_CNT && reset_powerdown_n_o) else $error("Read before wake-up time.");
	AST_WAKE_WRITE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$fell(write_en_n_o) |-> q.wake >= fbo_pkg::WAKE_WR_CNT) else $error("Write before recovery time.");
	AST_WE_FIRST: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$rose(write_en_n_o) |-> !chip_select_a_n_o ##1 chip_select_a_n_o || !clk_en_i) else $error("Chip select rose before write strobe.");
	AST_BYTE_DATA: assert property (@(posedge core_clk_i) disable iff (reset_i)
		rsp_valid_o && !byte_n_o |-> rsp_rdata_o[DATA_W-1:fbo_pkg::BYTE_W] == '0) else $error("Upper byte set in byte mode.");

	COV_READ: cover property (@(posedge core_clk_i) disable iff (reset_i) rsp_valid_o);
	COV_WRITE: cover property (@(posedge core_clk_i) disable iff (reset_i) $rose(write_en_n_o));
	COV_WAKE: cover property (@(posedge core_clk_i) disable iff (reset_i) $rose(reset_powerdown_n_o));
	COV_BUSY: cover property (@(posedge core_clk_i) disable iff (reset_i) $rose(busy_o));

endmodule
`default_nettype wire

// file: fbo_pkg.sv
/*
 * Shared constants and state codes for the parallel flash bus host.
 * Assumes a 125 MHz core clock; all times are converted to whole cycles here.
 */
`default_nettype none
package fbo_pkg;

	// ****************************************
	// Clock and counter widths
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int CNT_W = 8;
	localparam int BYTE_W = 8;

	// ****************************************
	// Pin timing, least times rounded up
	// ****************************************
	localparam int PD_MIN_NS = 100;
	localparam int WAKE_TO_READ_DELAY_NS = 600;
	localparam int WAKE_TO_WRITE_DELAY_NS = 1000;
	localparam int RD_ACCESS_NS = 100;
	localparam int WE_PULSE_NS = 50;
	localparam int BUS_GAP_NS = 30;

	localparam int PD_MIN_CYC = (PD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_RD_CYC = (WAKE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_WR_CYC = (WAKE_TO_WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC = (BUS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [CNT_W-1:0] PD_MIN_CNT = CNT_W'(PD_MIN_CYC);
	localparam logic [CNT_W-1:0] WAKE_RD_CNT = CNT_W'(WAKE_RD_CYC);
	localparam logic [CNT_W-1:0] WAKE_WR_CNT = CNT_W'(WAKE_WR_CYC);
	localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
	localparam logic [CNT_W-1:0] WE_CNT = CNT_W'(WE_CYC);
	localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(GAP_CYC);

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [5:0] {
		ST_PD = 6'h01,
		ST_IDLE = 6'h02,
		ST_RD = 6'h04,
		ST_WR = 6'h08,
		ST_WR_REL = 6'h10,
		ST_GAP = 6'h20
	} fbo_state_t;

endpackage
`default_nettype wire

// file: fbo_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one pin input.
 * Assumes the input is asynchronous to core_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module fbo_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic async_i,
	output logic sync_o
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic val;
	} fbo_sync_state_t;

	fbo_sync_state_t q, d;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		d.s1 = async_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// A change counts once the second and third stages agree.
		if (q.s2 == q.s3) begin
			d.val = q.s3;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, val: RST_VAL};
		end else if (clk_en_i) begin
			q <= d;
		end
	end

	assign sync_o = q.val;

endmodule
`default_nettype wire

// file: fbo_flash_model.sv
/*
 * Behavioural model of the parallel flash device at the host's pins.
 * Assumes the bench resolves the data and busy wires from the enables given here.
 */
`timescale 1ns/1ps
`default_nettype none
module fbo_flash_model #(
	parameter logic [15:0] MAKER = 16'h00A1, // Arbitrary value.
	parameter logic [15:0] PART = 16'h00B2, // Arbitrary value.
	parameter int PROG_NS = 800
) (
	input wire logic ce_a_n_i,
	input wire logic ce_b_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic rp_n_i,
	input wire logic byte_n_i,
	input wire logic [20:0] addr_i,
	input wire logic [15:0] din_i,
	output logic [15:0] dout_o,
	output logic [1:0] dout_en_o,
	output logic busy_en_o
);
	logic [1:0] mode_q = 2'h0;
	logic [7:0] sr_q = 8'h80;
	logic prog_q = 1'b0;
	logic busy_q = 1'b0;
	logic wr_q = 1'b0;
	int cnt_q = 0;
	// ****************************************
	// Pin decoding
	// ****************************************
	assign dout_en_o[0] = rp_n_i & ~ce_a_n_i & ~ce_b_n_i & ~oe_n_i & we_n_i;
	assign dout_en_o[1] = dout_en_o[0] & byte_n_i;
	assign busy_en_o = rp_n_i & busy_q;
	always_comb begin
		case (mode_q)
			2'h0: dout_o = addr_i[15:0] ^ 16'h3C3C;
			2'h1: dout_o = addr_i[1] ? 16'h0000 : (addr_i[0] ? PART : MAKER);
			2'h2: dout_o = {8'h00, (addr_i[5:0] < 6'h30) ? 8'h20 + 8'(addr_i[5:0]) : 8'h00};
			default: dout_o = {8'h00, sr_q};
		endcase
	end
	always @(negedge we_n_i or negedge ce_a_n_i or negedge ce_b_n_i) wr_q = ~we_n_i & ~ce_a_n_i & ~ce_b_n_i;
	always @(posedge we_n_i or posedge ce_a_n_i or posedge ce_b_n_i) begin
		if (wr_q && rp_n_i) begin
			wr_q = 1'b0;
			if (prog_q) begin
				prog_q = 1'b0;
				busy_q = 1'b1;
				sr_q = 8'h00;
				cnt_q = PROG_NS;
			end else begin
				case (din_i[7:0])
					8'hFF: mode_q = 2'h0;
					8'h90: mode_q = 2'h1;
					8'h98: mode_q = 2'h2;
					8'h70: mode_q = 2'h3;
					8'h40, 8'h10: prog_q = 1'b1;
					default: ;
				endcase
			end
		end
	end
	always @(negedge rp_n_i) begin
		busy_q = 1'b0;
		prog_q = 1'b0;
		cnt_q = 0;
	end
	always @(posedge rp_n_i) begin
		mode_q = 2'h0;
		sr_q = 8'h80;
	end
	always begin
		#1;
		if (cnt_q > 1) begin
			cnt_q = cnt_q - 1;
		end else if (busy_q) begin
			busy_q = 1'b0;
			sr_q = 8'h80;
		end
	end
endmodule
`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench for the flash host with a flash model on its pins.
 * Assumes fbo_pkg, fbo_sync, fbo_host and fbo_flash_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [15:0] MAKER_C = 16'h00A1;
	localparam logic [15:0] PART_C = 16'h00B2;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic valid = 1'b0;
	logic wr = 1'b0;
	logic pdn = 1'b0;
	logic bmode = 1'b0;
	logic tgl = 1'b0;
	logic [20:0] addr = 21'h000000;
	logic [15:0] wdata = 16'h0000;
	logic ready, rvalid, busy, foe, cs_a, cs_b, oe_n, we_n, rp_n, byte_n, mbusy;
	logic [20:0] faddr;
	logic [15:0] rdata, fdo, mdo;
	logic [1:0] men;
	wire [15:0] dq;
	wire sts;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	assign dq[7:0] = foe ? fdo[7:0] : men[0] ? mdo[7:0] : {8{tgl}} ^ 8'hA5;
	assign dq[15:8] = foe ? fdo[15:8] : men[1] ? mdo[15:8] : {8{tgl}} ^ 8'h5A;
	assign sts = mbusy ? 1'b0 : 1'b1;
	initial forever #4 clk = ~clk;
	fbo_host dut_u (.core_clk_i(clk), .reset_i(rst), .clk_en_i(1'b1), .req_valid_i(valid), .req_write_i(wr),
		.req_addr_i(addr), .req_wdata_i(wdata), .req_ready_o(ready), .rsp_valid_o(rvalid), .rsp_rdata_o(rdata),
		.pwrdown_i(pdn), .byte_mode_i(bmode), .busy_o(busy), .flash_addr_o(faddr), .data_lines_o(fdo),
		.data_lines_oe_o(foe), .data_lines_i(dq), .chip_select_a_n_o(cs_a), .chip_select_b_n_o(cs_b),
		.out_en_n_o(oe_n), .write_en_n_o(we_n), .reset_powerdown_n_o(rp_n), .byte_n_o(byte_n),
		.ready_busy_out_i(sts));
	fbo_flash_model #(.MAKER(MAKER_C), .PART(PART_C)) mdl_u (.ce_a_n_i(cs_a), .ce_b_n_i(cs_b), .oe_n_i(oe_n),
		.we_n_i(we_n), .rp_n_i(rp_n), .byte_n_i(byte_n), .addr_i(faddr), .din_i(dq), .dout_o(mdo),
		.dout_en_o(men), .busy_en_o(mbusy));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		tgl <= ~tgl;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [20:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(negedge clk);
		valid = 1'b1;
		wr = w;
		addr = a;
		wdata = d;
		#1;
		while (ready !== 1'b1 && n < 400) begin
			@(negedge clk);
			#1;
			n++;
		end
		if (n >= 400) err_total++;
		@(negedge clk);
		valid = 1'b0;
	endtask
	task automatic rd(input logic [20:0] a, output logic [15:0] q);
		int n;
		n = 0;
		bus(1'b0, a, 16'h0000);
		while (rvalid !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n >= 40) err_total++;
		q = rdata;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_boot;
		logic [15:0] q;
		repeat (3) @(negedge clk);
		chk(16'(rp_n), 16'h0000);
		rst = 1'b0;
		rd(21'h000012, q);
		chk(q, 16'h3C2E);
		$display("test boot done");
	endtask
	task automatic t_ident;
		logic [15:0] q;
		bus(1'b1, 21'h000000, 16'h0090);
		rd(21'h000000, q);
		chk(q, MAKER_C);
		rd(21'h000001, q);
		chk(q, PART_C);
		rd(21'h000002, q);
		chk(q, 16'h0000);
		$display("test ident done");
	endtask
	task automatic t_query;
		logic [15:0] q;
		bmode = 1'b1;
		bus(1'b1, 21'h000000, 16'h0098);
		rd(21'h000005, q);
		chk(q, 16'h0025);
		chk(16'(byte_n), 16'h0000);
		rd(21'h000031, q);
		chk(q, 16'h0000);
		bus(1'b1, 21'h000000, 16'h00FF);
		rd(21'h001234, q);
		chk(q, 16'h0008);
		bmode = 1'b0;
		$display("test query done");
	endtask
	task automatic t_prog(input logic [15:0] code);
		logic [15:0] q;
		int n;
		n = 0;
		bus(1'b1, 21'h000100, code);
		bus(1'b1, 21'h000100, 16'h1234);
		repeat (20) @(negedge clk);
		chk(16'(busy), 16'h0001);
		rd(21'h000000, q);
		chk(q, 16'h3C3C);
		chk(16'(busy), 16'h0001);
		while (busy !== 1'b0 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk(16'(busy), 16'h0000);
		$display("test program done");
	endtask
	task automatic t_abort;
		logic [15:0] q;
		bus(1'b1, 21'h000100, 16'h0040);
		bus(1'b1, 21'h000100, 16'h5678);
		repeat (20) @(negedge clk);
		pdn = 1'b1;
		repeat (30) @(negedge clk);
		chk(16'(rp_n), 16'h0000);
		chk(16'(busy), 16'h0000);
		pdn = 1'b0;
		rd(21'h000012, q);
		chk(q, 16'h3C2E);
		bus(1'b1, 21'h000000, 16'h0070);
		rd(21'h000000, q);
		chk(q, 16'h0080);
		$display("test abort done");
	endtask
	initial begin
		t_boot();
		t_ident();
		t_query();
		t_prog(16'h0040);
		t_prog(16'h0010);
		t_abort();
		tally_and_finish();
	end
endmodule
`default_nettype wire
